/* File: design/drc_pkg.sv */
// Constants and types for the DRAM refresh and error-correcting controller.
// Assumes a single 100 MHz clock shared by every design file.
package drc_pkg;
   localparam int          CLK_MHZ          = 100;
   localparam int          REF_PERIOD_US    = 125;
   localparam int          REF_PERIOD_CYC   = REF_PERIOD_US * CLK_MHZ;
   localparam int          REF_PER_PERIOD   = 8;
   localparam int          ROW_W            = 8;
   localparam int          ADDR_W           = 20;
   localparam int          DATA_W           = 16;
   localparam int          CHK_W            = 6;
   localparam int          COL_LSB          = 8;
   localparam int          RAS_CYC          = 2;
   localparam int          CAS_CYC          = 2;
   localparam int          RD_WAIT_CYC      = 3;
   localparam int          FIX_WAIT_CYC     = 2;
   localparam int          TALLY_W          = 4;
   localparam logic [3:0]  TALLY_NEED       = 4'h8;
   localparam logic [7:0]  ROW_RST          = 8'h00;

   typedef enum logic [1:0] {
      DRC_CYC_IDLE,
      DRC_CYC_READ,
      DRC_CYC_WRITE,
      DRC_CYC_OTHER
   } drc_cyc_t;

   typedef enum logic [1:0] {
      DRC_SEL_NONE,
      DRC_SEL_ROW,
      DRC_SEL_COL,
      DRC_SEL_REF
   } drc_sel_t;
endpackage

/* File: design/drc_ecc.sv */
// Modified Hamming check-bit generator and syndrome corrector for 16-bit words.
// Assumes purely combinational use from the same clock domain as its user.
`timescale 1ns/10ps
module drc_ecc
   import drc_pkg::*;
(
   input  wire logic [DATA_W-1:0] data_in,
   input  wire logic [CHK_W-1:0]  chk_in,
   output logic      [CHK_W-1:0]  chk_gen,
   output logic      [DATA_W-1:0] data_fix,
   output logic                   err_single,
   output logic                   err_double
);
   // Data bit i sits at Hamming position pos(i); positions that are powers of two hold checks
   function automatic logic [4:0] pos_of(input int i);
      int p;
      int k;
      p = 3;
      k = 0;
      for (int n = 3; n < 32; n++) begin
         if ((n & (n - 1)) != 0) begin
            if (k == i) begin
               p = n;
            end
            k++;
         end
      end
      return p[4:0];
   endfunction

   logic [4:0] syn;
   logic       ovr;

   always_comb begin
      logic [4:0] acc;
      acc = 5'h00;
      for (int i = 0; i < DATA_W; i++) begin
         if (data_in[i]) begin
            acc = acc ^ pos_of(i);
         end
      end
      // Overall parity bit makes double errors distinguishable
      chk_gen = {^{data_in, acc}, acc};
      syn     = acc ^ chk_in[4:0];
      ovr     = ^{data_in, chk_in};
      data_fix = data_in;
      for (int i = 0; i < DATA_W; i++) begin
         if (ovr && syn == pos_of(i)) begin
            data_fix[i] = ~data_in[i];
         end
      end
      err_single = ovr;
      err_double = !ovr && (syn != 5'h00);
   end
endmodule // drc_ecc

/* File: design/drc_ctrl.sv */
// DRAM controller with hidden and burst refresh and single-error correction.
// Assumes an external decoder supplies the cycle type, and the bench resolves tri-state pins.
// Function
// - Everything runs on one clock; the refresh timer counts it.
// - Access drives row strobe, then column strobe; write strobe on writes and on single-error read write-back.
// - Writes take no wait; check bits written with the data.
// - Reads insert at least one wait, released when no error.
// - A detected error adds two more wait states for correction.
// - Data pins float during read; corrected word captured into output registers.
// - After DRAM outputs turn off, drive corrected word back for CPU and DRAM.
// - Aim for eight row refreshes per 125 us period.
// - Non-memory cycles carry a hidden refresh with row strobe only, until eight are done in the period.
// - Missing refreshes at period end: hold processor, wait, burst them.
// - ALE-started timing machine makes strobes, wait, hold, counter clock, select.
// - Eight-bit refresh row counter, advanced by the timing machine.
// - Address mux shows row for row strobe, then column for column strobe.
// - Refresh shows counter value and pulses only the row strobe.
// - Writes compute six check bits with modified Hamming code.
// - Reads recompute and compare check bits, correcting correctable words.
// - Uncorrectable read error raises the non-maskable interrupt.
// - Address latched from the muxed bus; data feeds checker unregistered.
// - Row, column and refresh sources drive the address one at a time.
`timescale 1ns/10ps
module drc_ctrl
   import drc_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rstn,
   input  wire logic                 ale,
   input  wire drc_pkg::drc_cyc_t    cpu_cycle_status,
   input  wire logic [ADDR_W-1:0]    ad_in,
   input  wire logic [CHK_W-1:0]     chk_in,
   output logic      [DATA_W-1:0]    dq_out,
   output logic                      dq_oe,
   output logic      [CHK_W-1:0]     chk_out,
   output logic                      chk_oe,
   output logic      [ROW_W-1:0]     dram_addr,
   output logic                      ras_n,
   output logic                      cas_n,
   output logic                      we_n,
   output logic                      dram_oe_n,
   output logic                      cpu_wait,
   output logic                      cpu_hold,
   output logic                      nmi
);
   import drc_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_RAS,
      ST_CAS,
      ST_CHECK,
      ST_FIX,
      ST_WBACK,
      ST_REF,
      ST_REF_GAP,
      ST_DONE
   } drc_state_t;

   typedef struct packed {
      drc_state_t         st;
      logic [15:0]        tmr;
      logic [TALLY_W-1:0] tally;
      logic               burst;
      logic [TALLY_W-1:0] owed;
      logic [ROW_W-1:0]   row;
      logic [ADDR_W-1:0]  addr;
      logic               wr;
      logic               fix_ok;
      logic [2:0]         cnt;
      logic [DATA_W-1:0]  dq;
      logic               dq_oe;
      logic [CHK_W-1:0]   chk;
      logic               chk_oe;
      logic [ROW_W-1:0]   dram_addr;
      logic               ras_n;
      logic               cas_n;
      logic               we_n;
      logic               dram_oe_n;
      logic               wait_o;
      logic               hold_o;
      logic               nmi;
   } drc_regs_t;

   localparam logic [15:0] TMR_LAST = 16'(REF_PERIOD_CYC - 1);

   drc_regs_t r_q;
   drc_regs_t r_d;

   logic [CHK_W-1:0]  chk_gen;
   logic [DATA_W-1:0] data_fix;
   logic              err_single;
   logic              err_double;

   // Read data enters the checker straight from the pins, no register
   drc_ecc u_ecc (
      .data_in    (ad_in[DATA_W-1:0]),
      .chk_in     (chk_in),
      .chk_gen    (chk_gen),
      .data_fix   (data_fix),
      .err_single (err_single),
      .err_double (err_double)
   );

   drc_sel_t          addr_sel;
   logic [2:0]        src_en;
   logic [ROW_W-1:0]  src_row;
   logic [ROW_W-1:0]  src_col;
   logic [ROW_W-1:0]  src_ref;
   logic [ROW_W-1:0]  addr_bus;

   // Select decode mirrors the state machine below so the bus is ready in the same cycle
   always_comb begin
      addr_sel = DRC_SEL_NONE;
      unique case (r_q.st)
         ST_IDLE: begin
            if (r_q.burst) begin
               addr_sel = DRC_SEL_REF;
            end else if (ale) begin
               unique case (cpu_cycle_status)
                  DRC_CYC_READ, DRC_CYC_WRITE: begin
                     addr_sel = DRC_SEL_ROW;
                  end
                  DRC_CYC_OTHER: begin
                     if (r_q.tally < TALLY_NEED) begin
                        addr_sel = DRC_SEL_REF;
                     end
                  end
                  DRC_CYC_IDLE: begin
                  end
               endcase
            end
         end
         ST_RAS: begin
            if (r_q.cnt == 3'h0) begin
               addr_sel = DRC_SEL_COL;
            end
         end
         ST_REF_GAP: begin
            if (r_q.burst && r_q.owed != '0) begin
               addr_sel = DRC_SEL_REF;
            end
         end
         ST_CAS, ST_CHECK, ST_FIX, ST_WBACK, ST_REF, ST_DONE: begin
         end
         default: begin
         end
      endcase
   end

   assign src_row = ad_in[ROW_W-1:0];
   assign src_col = r_q.addr[COL_LSB+ROW_W-1:COL_LSB];
   assign src_ref = r_q.row;
   assign src_en  = {addr_sel == DRC_SEL_REF, addr_sel == DRC_SEL_COL, addr_sel == DRC_SEL_ROW};

   // One-hot enables stand in for the internal tri-state bus: never two drivers at once
   for (genvar b = 0; b < ROW_W; b++) begin : g_abus
      assign addr_bus[b] = (src_en[0] & src_row[b]) | (src_en[1] & src_col[b])
                         | (src_en[2] & src_ref[b]);
   end

   always_comb begin
      logic period_end;
      period_end = (r_q.tmr == TMR_LAST);
      r_d = r_q;
      // Free-running period timer on the system clock
      r_d.tmr = period_end ? 16'h0000 : r_q.tmr + 16'h0001;
      unique case (r_q.st)
         ST_IDLE: begin
            r_d.dq_oe     = 1'b0;
            r_d.chk_oe    = 1'b0;
            r_d.ras_n     = 1'b1;
            r_d.cas_n     = 1'b1;
            r_d.we_n      = 1'b1;
            r_d.dram_oe_n = 1'b1;
            if (r_q.burst) begin
               r_d.wait_o    = 1'b1;
               r_d.dram_addr = addr_bus;
               r_d.ras_n     = 1'b0;
               r_d.cnt       = 3'(RAS_CYC - 1);
               r_d.st        = ST_REF;
            end else if (ale) begin
               r_d.addr = ad_in;
               unique case (cpu_cycle_status)
                  DRC_CYC_READ, DRC_CYC_WRITE: begin
                     r_d.wr        = (cpu_cycle_status == DRC_CYC_WRITE);
                     r_d.dram_addr = addr_bus;
                     r_d.ras_n     = 1'b0;
                     r_d.wait_o    = (cpu_cycle_status == DRC_CYC_READ);
                     r_d.cnt       = 3'(RAS_CYC - 1);
                     r_d.st        = ST_RAS;
                  end
                  DRC_CYC_OTHER: begin
                     if (r_q.tally < TALLY_NEED) begin
                        r_d.dram_addr = addr_bus;
                        r_d.ras_n     = 1'b0;
                        r_d.cnt       = 3'(RAS_CYC - 1);
                        r_d.st        = ST_REF;
                     end
                  end
                  DRC_CYC_IDLE: begin
                  end
               endcase
            end
         end
         ST_RAS: begin
            if (r_q.cnt == 3'h0) begin
               r_d.dram_addr = addr_bus;
               r_d.cas_n     = 1'b0;
               r_d.cnt       = 3'(CAS_CYC - 1);
               if (r_q.wr) begin
                  r_d.we_n   = 1'b0;
                  // Processor data and fresh check bits go out together
                  r_d.dq     = ad_in[DATA_W-1:0];
                  r_d.chk    = chk_gen;
                  r_d.dq_oe  = 1'b1;
                  r_d.chk_oe = 1'b1;
                  r_d.st     = ST_DONE;
               end else begin
                  r_d.dram_oe_n = 1'b0;
                  r_d.dq_oe     = 1'b0;
                  r_d.cnt       = 3'(RD_WAIT_CYC - 1);
                  r_d.st        = ST_CHECK;
               end
            end else begin
               r_d.cnt = r_q.cnt - 3'h1;
            end
         end
         ST_CHECK: begin
            if (r_q.cnt == 3'h0) begin
               if (err_single || err_double) begin
                  r_d.dq     = data_fix;
                  r_d.fix_ok = err_single;
                  r_d.nmi    = r_q.nmi | err_double;
                  r_d.dram_oe_n = 1'b1;
                  r_d.cnt    = 3'(FIX_WAIT_CYC - 1);
                  r_d.st     = ST_FIX;
               end else begin
                  r_d.wait_o = 1'b0;
                  r_d.cnt    = 3'(CAS_CYC - 1);
                  r_d.st     = ST_DONE;
               end
            end else begin
               r_d.cnt = r_q.cnt - 3'h1;
            end
         end
         ST_FIX: begin
            // DRAM outputs are already off, so driving now cannot fight them
            if (r_q.fix_ok) begin
               r_d.dq_oe  = 1'b1;
               r_d.chk_oe = 1'b1;
            end
            // Check bits and write wait until the corrected word is on the pins
            if (r_q.fix_ok && r_q.dq_oe) begin
               r_d.chk  = chk_gen;
               r_d.we_n = 1'b0;
            end
            if (r_q.cnt == 3'h0) begin
               r_d.wait_o = 1'b0;
               r_d.st     = ST_WBACK;
            end else begin
               r_d.cnt = r_q.cnt - 3'h1;
            end
         end
         ST_WBACK: begin
            r_d.cnt = 3'(CAS_CYC - 1);
            r_d.st  = ST_DONE;
         end
         ST_REF: begin
            if (r_q.cnt == 3'h0) begin
               r_d.ras_n = 1'b1;
               r_d.row   = r_q.row + 8'h01;
               if (r_q.burst) begin
                  // Burst refreshes pay the old period's debt, not the new tally
                  r_d.owed = r_q.owed - 4'h1;
               end else if (r_q.tally < TALLY_NEED) begin
                  r_d.tally = r_q.tally + 4'h1;
               end
               r_d.st    = ST_REF_GAP;
            end else begin
               r_d.cnt = r_q.cnt - 3'h1;
            end
         end
         ST_REF_GAP: begin
            if (r_q.burst && r_q.owed != '0) begin
               r_d.dram_addr = addr_bus;
               r_d.ras_n     = 1'b0;
               r_d.cnt       = 3'(RAS_CYC - 1);
               r_d.st        = ST_REF;
            end else begin
               if (r_q.burst) begin
                  r_d.burst  = 1'b0;
                  r_d.hold_o = 1'b0;
                  r_d.wait_o = 1'b0;
               end
               r_d.st = ST_IDLE;
            end
         end
         ST_DONE: begin
            if (r_q.cnt == 3'h0) begin
               r_d.ras_n  = 1'b1;
               r_d.cas_n  = 1'b1;
               r_d.we_n   = 1'b1;
               r_d.dram_oe_n = 1'b1;
               r_d.dq_oe  = 1'b0;
               r_d.chk_oe = 1'b0;
               r_d.st     = ST_IDLE;
            end else begin
               r_d.cnt = r_q.cnt - 3'h1;
            end
         end
         default: r_d.st = ST_IDLE;
      endcase
      // Period end clears the tally; a shortfall becomes a burst debt and holds the processor
      if (period_end) begin
         r_d.tally = '0;
         if (r_q.tally < TALLY_NEED) begin
            r_d.burst  = 1'b1;
            r_d.hold_o = 1'b1;
            r_d.owed   = TALLY_NEED - r_q.tally;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r_q           <= '0;
         r_q.st        <= ST_IDLE;
         r_q.row       <= ROW_RST;
         r_q.ras_n     <= 1'b1;
         r_q.cas_n     <= 1'b1;
         r_q.we_n      <= 1'b1;
         r_q.dram_oe_n <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   assign dq_out    = r_q.dq;
   assign dq_oe     = r_q.dq_oe;
   assign chk_out   = r_q.chk;
   assign chk_oe    = r_q.chk_oe;
   assign dram_addr = r_q.dram_addr;
   assign ras_n     = r_q.ras_n;
   assign cas_n     = r_q.cas_n;
   assign we_n      = r_q.we_n;
   assign dram_oe_n = r_q.dram_oe_n;
   assign cpu_wait  = r_q.wait_o;
   assign cpu_hold  = r_q.hold_o;
   assign nmi       = r_q.nmi;
endmodule // drc_ctrl

/* File: bench/drc_dram_model.sv */
// Behavioural DRAM array holding 16 data plus 6 check bits per word.
// Assumes registered strobes from the controller; flip corrupts read data only.
`timescale 1ns/10ps
module drc_dram_model
   import drc_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             ras_n,
   input  wire logic             cas_n,
   input  wire logic             we_n,
   input  wire logic             dram_oe_n,
   input  wire logic [ROW_W-1:0] dram_addr,
   input  wire logic [21:0]      wr_word,
   input  wire logic [21:0]      flip,
   output logic      [21:0]      rd_word
);
   logic [21:0]      mem [0:65535];
   logic [ROW_W-1:0] row_q;
   logic [ROW_W-1:0] col_q;
   logic [ROW_W-1:0] col;
   logic             ras_q;
   logic             cas_q;
   logic             drv;
   logic [21:0]      last_q = 22'h2AAAAA;

   // Column is live in the cycle the column strobe falls
   assign col     = cas_q ? dram_addr : col_q;
   assign drv     = !dram_oe_n && !cas_n;
   // Released pins show the inverse so stale data never passes for a read
   assign rd_word = drv ? mem[{row_q, col}] ^ flip : ~last_q;

   always_ff @(posedge clk) begin
      ras_q <= ras_n;
      cas_q <= cas_n;
      if (!ras_n && ras_q) row_q <= dram_addr;
      if (!cas_n && cas_q) col_q <= dram_addr;
      if (!cas_n && !we_n) mem[{row_q, col}] <= wr_word;
      if (drv) last_q <= rd_word;
   end
endmodule // drc_dram_model

/* File: bench/drc_ctrl_properties.sv */
// Port checker for the DRAM controller, bound to its top module.
// Assumes ale is raised only while the controller is idle.
`timescale 1ns/10ps
module drc_ctrl_properties
   import drc_pkg::*;
(
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic              ale,
   input wire drc_pkg::drc_cyc_t cpu_cycle_status,
   input wire logic [ADDR_W-1:0] ad_in,
   input wire logic              dq_oe,
   input wire logic              chk_oe,
   input wire logic [ROW_W-1:0]  dram_addr,
   input wire logic              ras_n,
   input wire logic              cas_n,
   input wire logic              we_n,
   input wire logic              cpu_wait,
   input wire logic              cpu_hold,
   input wire logic              nmi
);
   logic              idle;
   logic [ADDR_W-1:0] ad_q;

   assign idle = ras_n && cas_n && !cpu_wait && !cpu_hold;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) ad_q <= '0;
      else if (ale && idle) ad_q <= ad_in;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_wr;
      ale && idle && cpu_cycle_status == DRC_CYC_WRITE;
   endsequence
   sequence s_rd;
      ale && idle && cpu_cycle_status == DRC_CYC_READ;
   endsequence
   sequence s_mem;
      ale && idle && (cpu_cycle_status == DRC_CYC_READ || cpu_cycle_status == DRC_CYC_WRITE);
   endsequence
   sequence s_ref;
      ale && idle && cpu_cycle_status == DRC_CYC_OTHER ##1 !ras_n;
   endsequence

   AST_WR_STROBES: assert property (s_wr |-> ##1 !ras_n ##2 !cas_n && !we_n && dq_oe && chk_oe)
      else $error("write strobes out of order");
   AST_WR_NO_WAIT: assert property (s_wr |-> ##1 !cpu_wait [*6])
      else $error("write raised wait");
   AST_RD_NO_WE: assert property (s_rd |-> ##1 we_n [*5])
      else $error("write strobe during read");
   AST_RD_FLOAT: assert property (s_rd |-> ##1 !dq_oe [*5])
      else $error("data driven during read");
   AST_RD_WAIT: assert property (s_rd |-> ##[1:2] cpu_wait ##[1:7] !cpu_wait)
      else $error("read wait missing or stuck");
   AST_ROW_COL: assert property (s_mem |-> ##1 dram_addr == ad_q[7:0] ##2 dram_addr == ad_q[15:8])
      else $error("row or column address wrong");
   AST_REF_RAS_ONLY: assert property (s_ref |-> (cas_n && we_n && !dq_oe) [*3])
      else $error("refresh pulsed more than row strobe");
   AST_HOLD_NO_CAS: assert property (cpu_hold |-> cas_n && we_n)
      else $error("column or write strobe during burst");
   AST_HOLD_WAIT: assert property ($rose(cpu_hold) |-> ##[0:1] cpu_wait)
      else $error("burst without wait");
   AST_NMI_STICKY: assert property (nmi |=> nmi)
      else $error("interrupt request dropped");
endmodule // drc_ctrl_properties

bind drc_ctrl drc_ctrl_properties u_props (
   .clk(clk), .rstn(rstn), .ale(ale), .cpu_cycle_status(cpu_cycle_status), .ad_in(ad_in),
   .dq_oe(dq_oe), .chk_oe(chk_oe), .dram_addr(dram_addr), .ras_n(ras_n), .cas_n(cas_n),
   .we_n(we_n), .cpu_wait(cpu_wait), .cpu_hold(cpu_hold), .nmi(nmi)
);

/* File: bench/drc_ctrl_test.sv */
// Self-checking bench: processor and decoder stand-in plus a DRAM model.
// Assumes the package timing; the period is long, so burst refresh runs last.
`timescale 1ns/10ps
module drc_ctrl_test;
   import drc_pkg::*;
   logic              clk, rstn, ale, cpu_drv;
   drc_cyc_t          cyc;
   logic [ADDR_W-1:0] cpu_ad, ad_in;
   logic [CHK_W-1:0]  chk_in, chk_out;
   logic [DATA_W-1:0] dq_out;
   logic [ROW_W-1:0]  dram_addr, row_exp;
   logic              dq_oe, chk_oe, ras_n, cas_n, we_n, dram_oe_n, cpu_wait, cpu_hold, nmi;
   logic [21:0]       flip, rd_word;
   int                num_errors, checks_done;

   // Shared data pins: processor, controller, then DRAM
   assign ad_in  = cpu_drv ? cpu_ad : {4'h0, dq_oe ? dq_out : rd_word[15:0]};
   assign chk_in = chk_oe ? chk_out : rd_word[21:16];

   drc_ctrl DUT (.clk(clk), .rstn(rstn), .ale(ale), .cpu_cycle_status(cyc), .ad_in(ad_in),
      .chk_in(chk_in), .dq_out(dq_out), .dq_oe(dq_oe), .chk_out(chk_out), .chk_oe(chk_oe),
      .dram_addr(dram_addr), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .dram_oe_n(dram_oe_n), .cpu_wait(cpu_wait), .cpu_hold(cpu_hold), .nmi(nmi));
   drc_dram_model u_dram (.clk(clk), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .dram_oe_n(dram_oe_n), .dram_addr(dram_addr), .wr_word({chk_in, ad_in[15:0]}),
      .flip(flip), .rd_word(rd_word));

   always #5 clk = ~clk;

   task automatic tick();
      @(posedge clk);
      #1;
   endtask

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // One processor cycle; rel: first cycle with wait low again, oe: first drive cycle, from 1
   task automatic access(drc_cyc_t kind, logic [15:0] addr, logic [15:0] data,
                         output int rel, output logic [15:0] got, output int oe);
      int   i;
      logic seen;
      seen = 1'b0;
      rel = 0;
      oe = 0;
      ale = 1'b1;
      cyc = kind;
      cpu_ad = {4'h0, addr};
      cpu_drv = 1'b1;
      tick();
      ale = 1'b0;
      cyc = DRC_CYC_IDLE;
      cpu_ad = {4'h0, data};
      cpu_drv = (kind == DRC_CYC_WRITE);
      for (i = 1; i < 20; i++) begin
         if (cpu_wait) got = ad_in[15:0];
         tick();
         if (dq_oe && oe == 0) oe = i + 1;
         if (cpu_wait) seen = 1'b1;
         else if (seen && rel == 0) rel = i + 1;
      end
      cpu_drv = 1'b0;
   endtask

   // Counts row-strobe falls; each must carry the next refresh row with no column strobe
   task automatic watch(int n, output int falls);
      int   i;
      logic ras_p;
      falls = 0;
      ras_p = 1'b1;
      for (i = 0; i < n; i++) begin
         tick();
         if (!ras_n && ras_p) begin
            falls++;
            check("refresh row", dram_addr, row_exp);
            row_exp++;
         end
         if (!ras_n) check("refresh cas_n", cas_n, 1'b1);
         ras_p = ras_n;
      end
   endtask

   task automatic sc_hidden();
      int f;
      repeat (3) begin
         ale = 1'b1;
         cyc = DRC_CYC_OTHER;
         tick();
         ale = 1'b0;
         cyc = DRC_CYC_IDLE;
         watch(8, f);
         check("hidden count", f, 1);
      end
   endtask

   task automatic sc_rw();
      int          k, rel, oe;
      logic [15:0] got, d;
      for (k = 0; k < 4; k++) begin
         d = (k == 0) ? 16'h0000 : (k == 1) ? 16'hFFFF : 16'hA5C3 + 16'(k);
         access(DRC_CYC_WRITE, 16'h3C00 + 16'(k * 257), d, rel, got, oe);
         check("write wait", rel, 0);
         check("write drive edge", oe, 3);
         access(DRC_CYC_READ, 16'h3C00 + 16'(k * 257), 16'h0000, rel, got, oe);
         check("read release", rel, 6);
         check("read data", got, d);
         check("read drive", oe, 0);
      end
   endtask

   // Every single bit, check bits included, is corrected and written back
   task automatic sc_single();
      int          b, rel, oe;
      logic [15:0] got;
      for (b = 0; b < 22; b++) begin
         access(DRC_CYC_WRITE, 16'h5A10 + 16'(b), 16'hC0DE ^ 16'(b), rel, got, oe);
         flip = 22'h000001 << b;
         access(DRC_CYC_READ, 16'h5A10 + 16'(b), 16'h0000, rel, got, oe);
         flip = '0;
         check("fix release", rel, 8);
         check("fix drive edge", oe, 7);
         check("fix data", got, 16'hC0DE ^ 16'(b));
         access(DRC_CYC_READ, 16'h5A10 + 16'(b), 16'h0000, rel, got, oe);
         check("writeback release", rel, 6);
      end
      check("nmi quiet", nmi, 1'b0);
   endtask

   task automatic sc_double();
      int          rel, oe;
      logic [15:0] got;
      access(DRC_CYC_WRITE, 16'h7700, 16'h1234, rel, got, oe);
      flip = 22'h000021;
      access(DRC_CYC_READ, 16'h7700, 16'h0000, rel, got, oe);
      flip = '0;
      check("nmi raised", nmi, 1'b1);
      check("double no drive", oe, 0);
   endtask

   // Only three hidden refreshes this period, so five must come as a burst
   task automatic sc_burst();
      int i, f;
      for (i = 0; i < 14000 && !cpu_hold; i++) tick();
      if (!cpu_hold) begin
         num_errors++;
         return;
      end
      watch(60, f);
      check("burst count", f, 5);
      check("hold released", cpu_hold, 1'b0);
      check("wait released", cpu_wait, 1'b0);
   endtask

   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      ale = 1'b0;
      cyc = DRC_CYC_IDLE;
      cpu_ad = '0;
      cpu_drv = 1'b0;
      flip = '0;
      row_exp = ROW_RST;
      num_errors = 0;
      checks_done = 0;
      repeat (16) @(posedge clk);
      #1;
      check("reset outputs", {ras_n, cas_n, we_n, dq_oe, cpu_wait, cpu_hold, nmi}, 7'h70);
      rstn = 1'b1;
      tick();
      sc_hidden();
      sc_rw();
      sc_single();
      sc_double();
      sc_burst();
      give_verdict();
   end
endmodule // drc_ctrl_test
